/* File: inc/pos_pkg.sv */
// package of constants for the pattern output stage
package pos_pkg;
  localparam int POS_CTRL_W = 6;
  localparam int POS_DATA_W = 16;
  localparam int POS_SEQ_MAX = 250;
  localparam int POS_WAVE_MAX = 10000000;
  localparam int POS_TRIG_LAT = 3;
  localparam logic [3:0] POS_REG_CTRL = 4'h0;
  localparam logic [3:0] POS_REG_CDIR = 4'h1;
  localparam logic [3:0] POS_REG_CDEF = 4'h2;
  localparam logic [3:0] POS_REG_CSEQ = 4'h3;
  localparam logic [3:0] POS_REG_DMASK = 4'h4;
  localparam logic [3:0] POS_REG_WAVE = 4'h5;
  localparam logic [3:0] POS_REG_TRIG = 4'h6;
  localparam logic [3:0] POS_REG_STAT = 4'h7;
  localparam logic [3:0] POS_REG_LOOP = 4'h8;
  localparam logic [3:0] POS_REG_WLEN = 4'h9;
  localparam logic [3:0] POS_REG_WPOS = 4'ha;
  localparam int POS_CTRL_START = 0;
  localparam int POS_CTRL_ABORT = 1;
  localparam int POS_CTRL_TRIGEN = 2;
  localparam int POS_CTRL_CLRSEQ = 3;
  localparam int POS_CTRL_CLRWAVE = 4;
  localparam int POS_LOOP_CNT_LSB = 0;
  localparam int POS_LOOP_REP_LSB = 16;
  localparam int POS_TRIG_PAT_LSB = 0;
  localparam int POS_TRIG_MASK_LSB = 8;
  typedef enum logic [1:0] {
    POS_IDLE = 2'b00,
    POS_ARMED = 2'b01,
    POS_DELAY = 2'b10,
    POS_RUN = 2'b11
  } pos_state_e;
endpackage

/* File: inc/pos_mem_if.sv */
// memory port bundle between the output stage and its waveform and sequence stores
`timescale 1ns/1ps
interface pos_mem_if #(parameter int AW = 8, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: src/pos_mem.sv */
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module pos_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic i_clk_sys,
  pos_mem_if.mem m
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rd;
  always_ff @(posedge i_clk_sys) begin
    if (m.we) begin
      store[m.waddr] <= m.wdata;
    end
    rd <= store[m.raddr];
  end
  assign m.rdata = rd;
endmodule // pos_mem

/* File: src/pos_output_stage.sv */
// pattern output stage: control sequencer and data waveform player
// Behaviour
// - control direction mask drives or floats lines
// - control word bit 5 is line 5
// - static mode drives default bits on outputs
// - sequence plays cyclically, at most 250 entries
// - nothing loaded keeps control sequencing off
// - data mask drives or floats data lines
// - data word bit 15 is line 15
// - waveform played in append order, 10M words; the store here holds 2^WAVE_AW words (1024 by default)
// - repeat group emitted n times, no nesting
// - last written sequence or default wins
// - trigger use wins over control sequence
// - data starts 3 cycles after trigger
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module pos_output_stage import pos_pkg::*; #(
  parameter int WAVE_AW = 10,
  parameter int SEQ_AW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [POS_CTRL_W-1:0] i_ctl_in,
  output logic [POS_CTRL_W-1:0] o_ctl_out,
  output logic [POS_CTRL_W-1:0] o_ctl_oe,
  output logic [POS_DATA_W-1:0] o_data_out,
  output logic [POS_DATA_W-1:0] o_data_oe
);
  // refuse store sizes that cannot hold the sequence or address the wave
  if ((1 << SEQ_AW) < POS_SEQ_MAX || SEQ_AW > 16 ||
      WAVE_AW > 24 || WAVE_AW < 2) begin : g_size_check
    $error("pos_output_stage: memory sizes out of range");
  end

  pos_mem_if #(.AW(WAVE_AW), .DW(POS_DATA_W)) wif ();
  pos_mem #(.AW(WAVE_AW), .DW(POS_DATA_W)) u_wave (
    .i_clk_sys(i_clk_sys),
    .m(wif.mem)
  );

  // sequence store, read address runs one step ahead of the pins
  pos_mem_if #(.AW(SEQ_AW), .DW(POS_CTRL_W)) sif ();
  pos_mem #(.AW(SEQ_AW), .DW(POS_CTRL_W)) u_seq (
    .i_clk_sys(i_clk_sys),
    .m(sif.mem)
  );

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] r,
                                  input logic w);
    return w && (a == r);
  endfunction

  // configuration state
  logic [POS_CTRL_W-1:0] cdir, next_cdir;
  logic [POS_CTRL_W-1:0] cdef, next_cdef;
  logic def_mode, next_def_mode;
  logic [POS_DATA_W-1:0] dmask, next_dmask;
  logic [POS_CTRL_W-1:0] tpat, next_tpat;
  logic [POS_CTRL_W-1:0] tmask, next_tmask;
  logic trig_en, next_trig_en;
  logic [SEQ_AW-1:0] seq_len, next_seq_len;
  logic [WAVE_AW:0] wlen, next_wlen;
  logic [15:0] lp_cnt, next_lp_cnt;
  logic [15:0] lp_rep, next_lp_rep;
  logic [WAVE_AW:0] lp_start, next_lp_start;

  // run state
  pos_state_e state, next_state;
  logic [1:0] dly, next_dly;
  logic [WAVE_AW:0] pos, next_pos;
  logic [15:0] rep_left, next_rep_left;
  logic [SEQ_AW-1:0] seq_idx, next_seq_idx;
  logic [POS_CTRL_W-1:0] ctl_out, next_ctl_out;
  logic [POS_CTRL_W-1:0] ctl_oe, next_ctl_oe;
  logic ctl_seq, next_ctl_seq;
  logic data_on, next_data_on;
  logic [31:0] rdata, next_rdata;

  always_comb begin
    next_cdir = cdir;
    next_cdef = cdef;
    next_def_mode = def_mode;
    next_dmask = dmask;
    next_tpat = tpat;
    next_tmask = tmask;
    next_trig_en = trig_en;
    next_seq_len = seq_len;
    next_wlen = wlen;
    next_lp_cnt = lp_cnt;
    next_lp_rep = lp_rep;
    next_lp_start = lp_start;
    sif.we = 1'b0;
    sif.waddr = seq_len;
    sif.wdata = i_wdata[POS_CTRL_W-1:0];
    wif.we = 1'b0;
    wif.waddr = wlen[WAVE_AW-1:0];
    wif.wdata = i_wdata[POS_DATA_W-1:0];
    if (wr_hit(i_addr, POS_REG_CDIR, i_wr)) begin
      next_cdir = i_wdata[POS_CTRL_W-1:0];
    end
    if (wr_hit(i_addr, POS_REG_CDEF, i_wr)) begin
      next_cdef = i_wdata[POS_CTRL_W-1:0];
      next_def_mode = 1'b1;
      next_seq_len = '0;
    end
    if (wr_hit(i_addr, POS_REG_CSEQ, i_wr) &&
        seq_len < SEQ_AW'(POS_SEQ_MAX)) begin
      sif.we = 1'b1;
      next_seq_len = seq_len + 1'b1;
      next_def_mode = 1'b0;
    end
    if (wr_hit(i_addr, POS_REG_DMASK, i_wr)) begin
      next_dmask = i_wdata[POS_DATA_W-1:0];
    end
    if (wr_hit(i_addr, POS_REG_WAVE, i_wr) && !wlen[WAVE_AW]) begin
      wif.we = 1'b1;
      next_wlen = wlen + 1'b1;
    end
    if (wr_hit(i_addr, POS_REG_TRIG, i_wr)) begin
      next_tpat = i_wdata[POS_TRIG_PAT_LSB +: POS_CTRL_W];
      next_tmask = i_wdata[POS_TRIG_MASK_LSB +: POS_CTRL_W];
    end
    if (wr_hit(i_addr, POS_REG_LOOP, i_wr)) begin
      // repeat group: the last cnt words appended so far, rep times
      next_lp_cnt = i_wdata[POS_LOOP_CNT_LSB +: 16];
      next_lp_rep = i_wdata[POS_LOOP_REP_LSB +: 16];
      next_lp_start = wlen - (WAVE_AW+1)'(i_wdata[POS_LOOP_CNT_LSB +: 16]);
    end
    if (wr_hit(i_addr, POS_REG_CTRL, i_wr)) begin
      next_trig_en = i_wdata[POS_CTRL_TRIGEN];
      if (i_wdata[POS_CTRL_CLRSEQ]) begin
        next_seq_len = '0;
        next_def_mode = 1'b0;
      end
      if (i_wdata[POS_CTRL_CLRWAVE]) begin
        next_wlen = '0;
        next_lp_cnt = '0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cdir <= '0;
      cdef <= '0;
      def_mode <= 1'b0;
      dmask <= '0;
      tpat <= '0;
      tmask <= '0;
      trig_en <= 1'b0;
      seq_len <= '0;
      wlen <= '0;
      lp_cnt <= '0;
      lp_rep <= '0;
      lp_start <= '0;
    end else begin
      cdir <= next_cdir;
      cdef <= next_cdef;
      def_mode <= next_def_mode;
      dmask <= next_dmask;
      tpat <= next_tpat;
      tmask <= next_tmask;
      trig_en <= next_trig_en;
      seq_len <= next_seq_len;
      wlen <= next_wlen;
      lp_cnt <= next_lp_cnt;
      lp_rep <= next_lp_rep;
      lp_start <= next_lp_start;
    end
  end

  // run control
  logic trig_hit;
  logic start_req;
  logic abort_req;
  logic [WAVE_AW:0] lp_end;
  assign trig_hit = ((i_ctl_in ^ tpat) & tmask) == '0;
  assign start_req = wr_hit(i_addr, POS_REG_CTRL, i_wr) &&
                     i_wdata[POS_CTRL_START];
  assign abort_req = wr_hit(i_addr, POS_REG_CTRL, i_wr) &&
                     i_wdata[POS_CTRL_ABORT];
  assign lp_end = lp_start + (WAVE_AW+1)'(lp_cnt);

  always_comb begin
    next_state = state;
    next_dly = dly;
    next_pos = pos;
    next_rep_left = rep_left;
    next_seq_idx = seq_idx;
    next_data_on = data_on;
    wif.raddr = pos[WAVE_AW-1:0];
    case (state)
      POS_IDLE: begin
        next_data_on = 1'b0;
        if (start_req && wlen != '0) begin
          next_pos = '0;
          next_seq_idx = '0;
          next_rep_left = (lp_rep == '0) ? 16'h0000 : lp_rep - 1'b1;
          next_state = trig_en ? POS_ARMED : POS_RUN;
          next_dly = '0;
        end
      end
      POS_ARMED: begin
        if (trig_hit) begin
          next_state = POS_DELAY;
          next_dly = 2'(POS_TRIG_LAT - 2);
        end
      end
      POS_DELAY: begin
        // first word is fetched in the first run cycle, while pos is still zero
        if (dly == '0) begin
          next_state = POS_RUN;
        end else begin
          next_dly = dly - 1'b1;
        end
      end
      POS_RUN: begin
        next_data_on = 1'b1;
        if (pos + 1'b1 == lp_end && lp_cnt != '0 && rep_left != '0) begin
          next_pos = lp_start;
          next_rep_left = rep_left - 1'b1;
        end else if (pos + 1'b1 >= wlen) begin
          next_state = POS_IDLE;
        end else begin
          next_pos = pos + 1'b1;
        end
        if (seq_len != '0) begin
          next_seq_idx = (seq_idx + 1'b1 >= seq_len) ? '0 :
                         seq_idx + 1'b1;
        end
      end
      default: next_state = POS_IDLE;
    endcase
    if (abort_req) begin
      next_state = POS_IDLE;
      next_data_on = 1'b0;
    end
    sif.raddr = next_seq_idx;
  end

  // control line drive
  always_comb begin
    next_ctl_oe = '0;
    next_ctl_out = '0;
    next_ctl_seq = 1'b0;
    if (def_mode) begin
      next_ctl_oe = cdir & ~(trig_en ? tmask : '0);
      next_ctl_out = cdef & next_ctl_oe;
    end else if (seq_len != '0 && (state == POS_RUN ||
                                   next_state == POS_RUN)) begin
      next_ctl_oe = cdir & ~(trig_en ? tmask : '0);
      next_ctl_seq = 1'b1;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        POS_REG_CDIR: next_rdata = 32'(cdir);
        POS_REG_CDEF: next_rdata = 32'(cdef);
        POS_REG_DMASK: next_rdata = 32'(dmask);
        POS_REG_TRIG: next_rdata = {16'h0000, 2'b00, tmask, 2'b00, tpat};
        POS_REG_STAT: next_rdata = {28'h0000000, def_mode, trig_hit,
                                    state};
        POS_REG_LOOP: next_rdata = {lp_rep, lp_cnt};
        POS_REG_WLEN: next_rdata = 32'(wlen);
        POS_REG_WPOS: next_rdata = 32'(pos);
        POS_REG_CTRL: next_rdata = {29'h00000000, trig_en, 2'b00};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= POS_IDLE;
      dly <= '0;
      pos <= '0;
      rep_left <= '0;
      seq_idx <= '0;
      ctl_out <= '0;
      ctl_oe <= '0;
      ctl_seq <= 1'b0;
      data_on <= 1'b0;
      rdata <= '0;
    end else begin
      state <= next_state;
      dly <= next_dly;
      pos <= next_pos;
      rep_left <= next_rep_left;
      seq_idx <= next_seq_idx;
      ctl_out <= next_ctl_out;
      ctl_oe <= next_ctl_oe;
      ctl_seq <= next_ctl_seq;
      data_on <= next_data_on;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
  assign o_ctl_out = ctl_seq ? (sif.rdata & ctl_oe) : ctl_out;
  assign o_ctl_oe = ctl_oe;
  assign o_data_out = data_on ? wif.rdata : '0;
  assign o_data_oe = data_on ? dmask : '0;
endmodule // pos_output_stage

/* File: tb/pos_cut_model.sv */
// circuit under test at the connector, resolving the shared lines
`timescale 1ns/1ps
module pos_cut_model import pos_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic [POS_CTRL_W-1:0] i_ctl_out,
  input wire logic [POS_CTRL_W-1:0] i_ctl_oe,
  input wire logic [POS_CTRL_W-1:0] i_ctl_drv,
  input wire logic [POS_DATA_W-1:0] i_data_out,
  input wire logic [POS_DATA_W-1:0] i_data_oe,
  output logic [POS_CTRL_W-1:0] o_ctl_line,
  output logic [POS_DATA_W-1:0] o_data_line
);
  logic [POS_DATA_W-1:0] noise = 16'h5a3c;
  // floating data lines carry a rotated, inverted noise word that changes every cycle
  always @(posedge i_clk_sys) noise <= ~{noise[14:0], noise[15]};
  // undriven control lines carry this side's trigger levels
  assign o_ctl_line = (i_ctl_out & i_ctl_oe) | (i_ctl_drv & ~i_ctl_oe);
  assign o_data_line = (i_data_out & i_data_oe) | (noise & ~i_data_oe);
endmodule // pos_cut_model

/* File: tb/pos_output_stage_checker.sv */
// port assertions for the pattern output stage
`timescale 1ns/1ps
module pos_output_stage_checker import pos_pkg::*; #(
  parameter int WAVE_AW = 10, parameter int SEQ_AW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [POS_CTRL_W-1:0] i_ctl_in,
  input wire logic [POS_CTRL_W-1:0] o_ctl_out,
  input wire logic [POS_CTRL_W-1:0] o_ctl_oe,
  input wire logic [POS_DATA_W-1:0] o_data_out,
  input wire logic [POS_DATA_W-1:0] o_data_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic [5:0] cdir, cdef, tmask, next_cdir, next_cdef, next_tmask;
  logic [15:0] dmask, next_dmask;
  logic te, st, sq, next_te, next_st, next_sq;
  // shadow of the configuration written over the register port
  always_comb begin
    {next_cdir, next_cdef} = {cdir, cdef};
    {next_tmask, next_dmask} = {tmask, dmask};
    {next_te, next_st, next_sq} = {te, st, sq};
    if (i_wr) begin
      case (i_addr)
        POS_REG_CTRL: begin
          next_te = i_wdata[POS_CTRL_TRIGEN];
          if (i_wdata[POS_CTRL_CLRSEQ]) {next_st, next_sq} = 2'b00;
        end
        POS_REG_CDIR: next_cdir = i_wdata[5:0];
        POS_REG_CDEF: {next_cdef, next_st, next_sq} = {i_wdata[5:0], 2'b10};
        POS_REG_CSEQ: {next_st, next_sq} = 2'b01;
        POS_REG_DMASK: next_dmask = i_wdata[15:0];
        POS_REG_TRIG: next_tmask = i_wdata[13:8];
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst) {cdir, cdef, tmask, dmask, te, st, sq} <= '0;
    else {cdir, cdef, tmask, dmask, te, st, sq} <=
      {next_cdir, next_cdef, next_tmask, next_dmask,
       next_te, next_st, next_sq};
  sequence s_abort;
    i_wr && i_addr == POS_REG_CTRL && i_wdata[POS_CTRL_ABORT];
  endsequence
  sequence s_float;
    ##1 o_data_oe == '0;
  endsequence
  chk_reset_float: assert property (disable iff (1'b0)
    i_rst |-> o_ctl_oe == '0 && o_data_oe == '0)
    else $error("lines driven in reset");
  chk_cdir_last: assert property (
    i_rd && i_addr == POS_REG_CDIR |=> o_rdata[5:0] == cdir)
    else $error("cdir readback");
  chk_dmask_last: assert property (
    i_rd && i_addr == POS_REG_DMASK |=> o_rdata[15:0] == dmask)
    else $error("dmask readback");
  chk_ctl_dir: assert property (
    (o_ctl_oe & ~$past(cdir)) == '0)
    else $error("control line not output driven");
  chk_static_lvl: assert property (st && $past(st) |->
    ((o_ctl_out ^ $past(cdef)) & o_ctl_oe) == '0)
    else $error("static level wrong");
  chk_seq_off: assert property (
    !st && !sq && !$past(st) && !$past(sq) |-> o_ctl_oe == '0)
    else $error("control driven with nothing loaded");
  chk_trig_free: assert property (te && $past(te) |->
    (o_ctl_oe & $past(tmask)) == '0)
    else $error("trigger line driven");
  chk_data_mask: assert property (
    o_data_oe != '0 |-> o_data_oe == dmask)
    else $error("data enable not mask");
  chk_abort_float: assert property (
    s_abort |-> s_float)
    else $error("data driven after abort");
endmodule // pos_output_stage_checker
bind pos_output_stage pos_output_stage_checker #(.WAVE_AW(WAVE_AW),
  .SEQ_AW(SEQ_AW)) chk_u (.*);

/* File: tb/tb.sv */
// self-checking bench for the pattern output stage
`timescale 1ns/1ps
module tb import pos_pkg::*;;
  logic i_clk_sys = 0, i_rst = 0, i_wr = 0, i_rd = 0, rd_d = 0, on_d = 0;
  logic seq_on = 0;
  logic [3:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, t0, t_first, cyc = 0, rd_q[$];
  logic [5:0] o_ctl_out, o_ctl_oe, ctl_line, drv = '0, cd, df, cq[$];
  logic [5:0] pats[3] = '{6'h15, 6'h2a, 6'h0f};
  logic [15:0] o_data_out, o_data_oe, data_line, dm, w[8], exp_q[$];
  int num_errors = 0, total_checks = 0, seed = 32'h9373, k;
  initial forever #10 i_clk_sys = ~i_clk_sys;
  pos_output_stage dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ctl_in(ctl_line), .o_ctl_out(o_ctl_out),
    .o_ctl_oe(o_ctl_oe), .o_data_out(o_data_out), .o_data_oe(o_data_oe));
  pos_cut_model cut_u (.i_clk_sys(i_clk_sys), .i_ctl_out(o_ctl_out),
    .i_ctl_oe(o_ctl_oe), .i_ctl_drv(drv), .i_data_out(o_data_out),
    .i_data_oe(o_data_oe), .o_ctl_line(ctl_line), .o_data_line(data_line));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    rd_q.push_back(e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask
  task automatic load_exp();
    for (int i = 0; i < 6; i++) exp_q.push_back(w[i]);
    repeat (3) for (int i = 6; i < 8; i++) exp_q.push_back(w[i]);
  endtask
  task automatic drain();
    for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge i_clk_sys);
    chk("words left", exp_q.size(), 0);
  endtask
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  always @(negedge i_clk_sys) begin
    if (rd_d) chk("read data", o_rdata, rd_q.pop_front());
    if (o_data_oe != '0) begin
      if (!on_d) t_first = cyc;
      if (seq_on) cq.push_back(o_ctl_out);
      chk("data enable", o_data_oe, dm);
      if (exp_q.size() == 0) chk("extra word", 1, 0);
      else chk("data lines", data_line & dm, exp_q.pop_front() & dm);
    end
    on_d = (o_data_oe != '0);
  end
  initial begin
    // a real edge on reset at time zero clears every resettable flop before the clock
    i_rst <= 1'b1;
    for (int i = 0; i < 8; i++) w[i] = 16'($random(seed));
    cd = 6'($random(seed));
    df = 6'($random(seed));
    dm = 16'($random(seed)) | 16'h1;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk("reset ctl enable", o_ctl_oe, 0);
    chk("reset data enable", o_data_oe, 0);
    wr(POS_REG_CDIR, 32'h3f);
    wr(POS_REG_CDIR, {26'h0, cd});
    wr(POS_REG_DMASK, {16'h0, dm});
    rd(POS_REG_CDIR, {26'h0, cd});
    rd(POS_REG_DMASK, {16'h0, dm});
    rd(4'hf, 32'h0);
    wr(POS_REG_CDEF, 32'h2a);
    wr(POS_REG_CDEF, {26'h0, df});
    repeat (3) @(negedge i_clk_sys);
    chk("ctl enable", o_ctl_oe, cd);
    chk("ctl level", o_ctl_out & cd, df & cd);
    for (int i = 0; i < 8; i++) wr(POS_REG_WAVE, {16'h0, w[i]});
    wr(POS_REG_LOOP, 32'h0003_0002);
    wr(POS_REG_CDIR, 32'h3f);
    wr(POS_REG_CTRL, 32'h8);
    for (int i = 0; i < 3; i++) wr(POS_REG_CSEQ, {26'h0, pats[i]});
    load_exp();
    seq_on = 1;
    wr(POS_REG_CTRL, 32'h1);
    drain();
    seq_on = 0;
    for (int i = 0; i + 1 < cq.size(); i++)
      for (int j = 0; j < 3; j++)
        if (cq[i] === pats[j])
          chk("ctl order", cq[i+1], pats[(j+1)%3]);
    wr(POS_REG_TRIG, 32'h0505);
    // start looks at the trigger enable already held, so set it first
    wr(POS_REG_CTRL, 32'h4);
    load_exp();
    wr(POS_REG_CTRL, 32'h5);
    repeat (6) @(negedge i_clk_sys);
    chk("armed words", exp_q.size(), 12);
    @(posedge i_clk_sys);
    drv <= 6'h05;
    t0 = cyc;
    drain();
    chk("trigger delay", t_first, t0 + 5);
    load_exp();
    wr(POS_REG_CTRL, 32'h1);
    repeat (4) @(posedge i_clk_sys);
    wr(POS_REG_CTRL, 32'h2);
    repeat (2) @(negedge i_clk_sys);
    exp_q.delete();
    chk("abort enable", o_data_oe, 0);
    repeat (5) @(negedge i_clk_sys);
    end_of_test();
  end
endmodule // tb
